// ### common/csfi_pkg.sv
// Constants shared by the charger status and fault interrupt block
package csfi_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned ALERT_US      = 256;
  localparam int unsigned ALERT_CYC     = ALERT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BLINK_HZ      = 1;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned PUMP_PHASE_MS = 100;
  localparam int unsigned PUMP_PHASE_CYC = PUMP_PHASE_MS * (CLK_HZ / 1_000);
  localparam int unsigned TMR_W         = 26;
  localparam logic [2:0]  PUMP_PULSES   = 3'h3;
  localparam logic [2:0]  BOOST_RETRY   = 3'h7;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] A_CTRL0  = 8'h00;
  localparam logic [7:0] A_CTRL1  = 8'h01;
  localparam logic [7:0] A_PUMP   = 8'h02;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_FAULT  = 8'h09;
  localparam logic [7:0] A_FLAG   = 8'h0e;
  localparam logic [7:0] A_LAST   = 8'h0f;
  localparam logic [7:0] RD_BEYOND = 8'hff;
  localparam logic [7:0] RD_NONE   = 8'h00;

  // ==========================================================
  // Field positions
  localparam int unsigned C0_SEL_LSB  = 5;
  localparam int unsigned C0_ILIM_LSB = 0;
  localparam int unsigned C1_BOOST    = 7;
  localparam int unsigned C1_OVP_LSB  = 5;
  localparam int unsigned C1_MASK     = 4;
  localparam int unsigned C1_MAN_LSB  = 0;
  localparam int unsigned PU_EN       = 7;
  localparam int unsigned PU_UP       = 1;
  localparam int unsigned PU_DN       = 0;

  // ==========================================================
  // Reset values and encodings
  localparam logic [4:0] ILIM_RST   = 5'h17;
  localparam logic [4:0] ILIM_100MA = 5'h00;
  localparam logic [1:0] OVP_RST    = 2'h3;
  localparam logic [1:0] SEL_NORMAL = 2'h0;
  localparam logic [1:0] SEL_MANUAL = 2'h1;
  localparam logic [1:0] MAN_DRIVE  = 2'h1;
  localparam logic [1:0] MAN_BLINK  = 2'h2;
  localparam logic [1:0] CFC_NONE   = 2'h0;
  localparam logic [1:0] CFC_INOV   = 2'h1;
  localparam logic [1:0] CFC_TSHUT  = 2'h2;
  localparam logic [2:0] TYPE_NONE  = 3'h0;

  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_LOW  = 3'b010,
    PS_HIGH = 3'b100
  } csfi_pstate_t;
endpackage

// ### design/csfi_timer.sv
// Loadable down counter used for pulse, blink and pump phase timing
`timescale 1ns/1ps
module csfi_timer #(
  parameter int unsigned W = 26
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              busy,
  output logic              done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } csfi_tmr_t;

  csfi_tmr_t s_q;
  csfi_tmr_t s_d;

  // ==========================================================
  // Count down from the loaded value
  always_comb begin
    s_d = s_q;
    if (start) begin
      s_d.cnt = load;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.cnt != '0);
  assign done = (s_q.cnt == W'(1));
endmodule // csfi_timer

// ### design/csfi_top.sv
// Charger status indicator, host alert pulse, fault latches and pump protocol
// ==========================================================
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
module csfi_top #(
  parameter int unsigned ALERT_CYC      = csfi_pkg::ALERT_CYC,
  parameter int unsigned BLINK_HALF_CYC = csfi_pkg::BLINK_HALF_CYC,
  parameter int unsigned PUMP_PHASE_CYC = csfi_pkg::PUMP_PHASE_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  input  wire logic       chg_active,
  input  wire logic       chg_done,
  input  wire logic       timer_fault,
  input  wire logic       sys_ovp,
  input  wire logic [2:0] thermistor_fault,
  input  wire logic [3:0] ovp_cmp,
  input  wire logic       boost_mode,
  input  wire logic       boost_short,
  input  wire logic       boost_ovp,
  input  wire logic       therm_reg,
  input  wire logic       tshut,
  input  wire logic       bat_ovp,
  input  wire logic       src_detected,
  input  wire logic [2:0] input_type_raw,
  input  wire logic       power_good_raw,
  input  wire logic       input_good_raw,
  input  wire logic       dpm_active,
  output logic            ind_o,
  output logic            ind_oe,
  output logic            host_alert_n,
  output logic      [4:0] input_current_limit,
  output logic            boost_enable,
  output logic            conv_stop,
  output logic            bat_sw_off,
  output logic            chg_stop,
  output logic            timer_half_rate,
  output logic            term_disable
);
  localparam int unsigned TW = csfi_pkg::TMR_W;

  typedef struct packed {
    logic [1:0]           ind_sel;
    logic [1:0]           ind_man;
    logic [4:0]           ilim;
    logic [1:0]           ovp_sel;
    logic                 dpm_mask;
    logic                 boost_en;
    logic                 pump_en;
    logic                 raise;
    logic                 lower;
    csfi_pkg::csfi_pstate_t ps;
    logic [2:0]           pcnt;
    logic [2:0]           retry;
    logic                 boost_fault;
    logic                 lat_inov;
    logic                 lat_tshut;
    logic                 lat_bovp;
    logic                 lat_good;
    logic                 lat_done;
    logic                 lat_src;
    logic                 lat_dpm;
    logic                 p_inov;
    logic                 p_tshut;
    logic                 p_bovp;
    logic                 p_done;
    logic                 p_src;
    logic                 p_good;
    logic                 p_dpm;
    logic                 p_short;
    logic                 p_bfault;
    logic                 armed;
    logic                 seen_ft;
    logic                 seen_fl;
    logic                 alert_n;
    logic                 blink;
    logic                 ind_o;
    logic                 ind_oe;
    logic [4:0]           eff_ilim;
    logic                 conv_stop;
    logic                 bat_sw_off;
    logic                 chg_stop;
    logic                 half_rate;
    logic                 term_dis;
    logic [7:0]           rdata;
  } csfi_st_t;

  csfi_st_t s_q;
  csfi_st_t s_d;

  logic inov;
  logic k_tshut;
  logic b_tshut;
  logic gd;
  logic susp;
  logic wr_c0;
  logic wr_c1;
  logic wr_pu;
  logic rd_ft;
  logic rd_fl;
  logic ev_any;
  logic fire;
  logic pump_go;
  logic pump_start;
  logic a_busy;
  logic a_done;
  logic b_busy;
  logic b_done;
  logic p_done;

  // ==========================================================
  // Live conditions and decode
  assign inov    = ovp_cmp[s_q.ovp_sel];
  assign k_tshut = tshut & ~boost_mode;
  assign b_tshut = tshut & boost_mode;
  assign gd      = input_good_raw & ~k_tshut;
  assign susp    = ((inov | (|thermistor_fault) | timer_fault | sys_ovp) & ~boost_mode)
                 | (boost_mode & (|thermistor_fault));
  // Each access touches its own address only; no increment exists
  assign wr_c0 = wr_en && (addr == csfi_pkg::A_CTRL0);
  assign wr_c1 = wr_en && (addr == csfi_pkg::A_CTRL1);
  assign wr_pu = wr_en && (addr == csfi_pkg::A_PUMP);
  assign rd_ft = rd_en && (addr == csfi_pkg::A_FAULT);
  assign rd_fl = rd_en && (addr == csfi_pkg::A_FLAG);

  // ==========================================================
  // Alert events
  assign ev_any = (inov & ~s_q.p_inov)
                | (k_tshut & ~s_q.p_tshut)
                | (bat_ovp & ~s_q.p_bovp)
                | (s_q.boost_fault & ~s_q.p_bfault)
                | (chg_done & ~s_q.p_done)
                | (src_detected & ~s_q.p_src)
                | (gd ^ s_q.p_good)
                | (dpm_active & ~s_q.p_dpm & ~s_q.dpm_mask);
  assign fire = ev_any & s_q.armed & s_q.alert_n;

  // ==========================================================
  // Pump sequence starts
  assign pump_go = wr_pu && s_q.pump_en && wdata[csfi_pkg::PU_EN]
                && (s_q.ps == csfi_pkg::PS_IDLE)
                && (wdata[csfi_pkg::PU_UP] ^ wdata[csfi_pkg::PU_DN]);
  assign pump_start = pump_go
                   || (p_done && (s_q.ps == csfi_pkg::PS_LOW))
                   || (p_done && (s_q.ps == csfi_pkg::PS_HIGH)
                       && (s_q.pcnt != csfi_pkg::PUMP_PULSES - 3'h1));

  // ==========================================================
  // Timers
  csfi_timer #(.W(TW)) u_alert_tmr (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (fire),
    .load     (TW'(ALERT_CYC)),
    .busy     (a_busy),
    .done     (a_done)
  );

  csfi_timer #(.W(TW)) u_blink_tmr (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (b_done || !b_busy),
    .load     (TW'(BLINK_HALF_CYC)),
    .busy     (b_busy),
    .done     (b_done)
  );

  csfi_timer #(.W(TW)) u_pump_tmr (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (pump_start),
    .load     (TW'(PUMP_PHASE_CYC)),
    .busy     (),
    .done     (p_done)
  );

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // Control writes
    if (wr_c0) begin
      s_d.ind_sel = wdata[csfi_pkg::C0_SEL_LSB +: 2];
      s_d.ilim    = wdata[csfi_pkg::C0_ILIM_LSB +: 5];
    end
    if (wr_c1) begin
      s_d.ovp_sel  = wdata[csfi_pkg::C1_OVP_LSB +: 2];
      s_d.dpm_mask = wdata[csfi_pkg::C1_MASK];
      s_d.ind_man  = wdata[csfi_pkg::C1_MAN_LSB +: 2];
      s_d.boost_en = wdata[csfi_pkg::C1_BOOST];
      if (wdata[csfi_pkg::C1_BOOST] && !s_q.boost_en) begin
        s_d.boost_fault = 1'b0;
        s_d.retry       = 3'h0;
      end
    end
    if (wr_pu) begin
      s_d.pump_en = wdata[csfi_pkg::PU_EN];
    end

    // Boost protections win over a same-cycle enable write
    if (boost_short && !s_q.p_short && s_q.boost_en) begin
      if (s_q.retry == csfi_pkg::BOOST_RETRY) begin
        s_d.boost_en    = 1'b0;
        s_d.boost_fault = 1'b1;
      end else begin
        s_d.retry = s_q.retry + 3'h1;
      end
    end
    if (boost_ovp && s_d.boost_en) begin
      s_d.boost_en    = 1'b0;
      s_d.boost_fault = 1'b1;
    end
    if (b_tshut) begin
      s_d.boost_en = 1'b0;
    end

    // Pump protocol
    unique case (s_q.ps)
      csfi_pkg::PS_IDLE: begin
        if (pump_go) begin
          s_d.raise = wdata[csfi_pkg::PU_UP];
          s_d.lower = wdata[csfi_pkg::PU_DN];
          s_d.pcnt  = 3'h0;
          s_d.ps    = csfi_pkg::PS_LOW;
        end
      end
      csfi_pkg::PS_LOW: begin
        if (wr_pu && !wdata[csfi_pkg::PU_EN]) begin
          s_d.ps = csfi_pkg::PS_IDLE;
        end else if (p_done) begin
          s_d.ps = csfi_pkg::PS_HIGH;
        end
      end
      csfi_pkg::PS_HIGH: begin
        if (wr_pu && !wdata[csfi_pkg::PU_EN]) begin
          s_d.ps = csfi_pkg::PS_IDLE;
        end else if (p_done) begin
          if (s_q.pcnt == csfi_pkg::PUMP_PULSES - 3'h1) begin
            s_d.ps = csfi_pkg::PS_IDLE;
          end else begin
            s_d.pcnt = s_q.pcnt + 3'h1;
            s_d.ps   = csfi_pkg::PS_LOW;
          end
        end
      end
      default: begin
        s_d.ps = csfi_pkg::PS_IDLE;
      end
    endcase
    if (s_d.ps == csfi_pkg::PS_IDLE) begin
      s_d.raise = 1'b0;
      s_d.lower = 1'b0;
    end
    s_d.eff_ilim = (s_d.ps == csfi_pkg::PS_LOW) ? csfi_pkg::ILIM_100MA
                                                 : s_d.ilim;

    // Fault latches: a read reloads the live state
    s_d.lat_inov  = (rd_ft ? 1'b0 : s_q.lat_inov) | inov;
    s_d.lat_tshut = (rd_ft ? 1'b0 : s_q.lat_tshut) | k_tshut;
    s_d.lat_bovp  = (rd_ft ? 1'b0 : s_q.lat_bovp) | bat_ovp;

    // Flag latches: a read clears, a new event wins
    s_d.lat_good = (rd_fl ? 1'b0 : s_q.lat_good) | (gd ^ s_q.p_good);
    s_d.lat_done = (rd_fl ? 1'b0 : s_q.lat_done) | (chg_done & ~s_q.p_done);
    s_d.lat_src  = (rd_fl ? 1'b0 : s_q.lat_src) | (src_detected & ~s_q.p_src);
    s_d.lat_dpm  = (rd_fl ? 1'b0 : s_q.lat_dpm) | (dpm_active & ~s_q.p_dpm);

    // Edge history
    s_d.p_inov   = inov;
    s_d.p_tshut  = k_tshut;
    s_d.p_bovp   = bat_ovp;
    s_d.p_done   = chg_done;
    s_d.p_src    = src_detected;
    s_d.p_good   = gd;
    s_d.p_dpm    = dpm_active;
    s_d.p_short  = boost_short;
    s_d.p_bfault = s_q.boost_fault;

    // Alert arming
    if (fire) begin
      s_d.armed   = 1'b0;
      s_d.seen_ft = 1'b0;
      s_d.seen_fl = 1'b0;
    end else begin
      if (rd_ft) begin
        s_d.seen_ft = 1'b1;
      end
      if (rd_fl) begin
        s_d.seen_fl = 1'b1;
      end
      if (s_d.seen_ft && s_d.seen_fl
          && !(s_d.lat_inov | s_d.lat_tshut | s_d.lat_bovp | s_d.lat_good
               | s_d.lat_done | s_d.lat_src | s_d.lat_dpm)) begin
        s_d.armed = 1'b1;
      end
    end
    s_d.alert_n = !(fire || (a_busy && !a_done));

    // Indicator
    if (b_done) begin
      s_d.blink = ~s_q.blink;
    end
    s_d.ind_o = 1'b0;
    if (s_q.ind_sel == csfi_pkg::SEL_NORMAL) begin
      if (susp) begin
        s_d.ind_oe = s_q.blink;
      end else begin
        s_d.ind_oe = chg_active;
      end
    end else if (s_q.ind_sel == csfi_pkg::SEL_MANUAL) begin
      s_d.ind_oe = (s_q.ind_man == csfi_pkg::MAN_DRIVE)
                || ((s_q.ind_man == csfi_pkg::MAN_BLINK) && s_q.blink);
    end else begin
      s_d.ind_oe = 1'b0;
    end

    // Protection outputs
    s_d.conv_stop  = k_tshut | (inov & ~boost_mode)
                   | (boost_mode & (boost_ovp | s_q.boost_fault));
    s_d.bat_sw_off = b_tshut;
    s_d.chg_stop   = bat_ovp;
    s_d.half_rate  = therm_reg;
    s_d.term_dis   = therm_reg;

    // Read data
    s_d.rdata = csfi_pkg::RD_NONE;
    if (rd_en) begin
      case (addr)
        csfi_pkg::A_CTRL0: s_d.rdata = {1'b0, s_q.ind_sel, s_q.ilim};
        csfi_pkg::A_CTRL1: s_d.rdata = {s_q.boost_en, s_q.ovp_sel, s_q.dpm_mask,
                                        2'b00, s_q.ind_man};
        csfi_pkg::A_PUMP: s_d.rdata = {s_q.pump_en, 5'h00, s_q.raise, s_q.lower};
        csfi_pkg::A_STATUS: s_d.rdata = {k_tshut ? csfi_pkg::TYPE_NONE : input_type_raw,
                                         power_good_raw & ~k_tshut, gd, therm_reg,
                                         chg_active, chg_done};
        csfi_pkg::A_FAULT: s_d.rdata = {1'b0, s_q.boost_fault,
                                        s_q.lat_tshut ? csfi_pkg::CFC_TSHUT
                                        : (s_q.lat_inov ? csfi_pkg::CFC_INOV
                                                        : csfi_pkg::CFC_NONE),
                                        s_q.lat_bovp, thermistor_fault};
        csfi_pkg::A_FLAG: s_d.rdata = {4'h0, s_q.lat_good, s_q.lat_done,
                                       s_q.lat_src, s_q.lat_dpm};
        default: begin
          if (addr > csfi_pkg::A_LAST) begin
            s_d.rdata = csfi_pkg::RD_BEYOND;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q          <= '0;
      s_q.ilim     <= csfi_pkg::ILIM_RST;
      s_q.eff_ilim <= csfi_pkg::ILIM_RST;
      s_q.ovp_sel  <= csfi_pkg::OVP_RST;
      s_q.ps       <= csfi_pkg::PS_IDLE;
      s_q.armed    <= 1'b1;
      s_q.alert_n  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata               = s_q.rdata;
  assign ind_o               = s_q.ind_o;
  assign ind_oe              = s_q.ind_oe;
  assign host_alert_n        = s_q.alert_n;
  assign input_current_limit = s_q.eff_ilim;
  assign boost_enable        = s_q.boost_en;
  assign conv_stop           = s_q.conv_stop;
  assign bat_sw_off          = s_q.bat_sw_off;
  assign chg_stop            = s_q.chg_stop;
  assign timer_half_rate     = s_q.half_rate;
  assign term_disable        = s_q.term_dis;
endmodule // csfi_top

// ### tb/csfi_checker.sv
// Port assertions for the status, alert, fault and pump block
`timescale 1ns/1ps
module csfi_checker #(
  parameter int unsigned ALERT_CYC = 16
) (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  input wire logic       host_alert_n,
  input wire logic       bat_ovp,
  input wire logic       chg_stop,
  input wire logic       tshut,
  input wire logic       boost_mode,
  input wire logic       boost_ovp,
  input wire logic       conv_stop,
  input wire logic       boost_enable,
  input wire logic       bat_sw_off,
  input wire logic       therm_reg,
  input wire logic       timer_half_rate,
  input wire logic       term_disable,
  input wire logic [4:0] input_current_limit
);
  logic [15:0] low_q;
  // ==========================================================
  // Alert low time
  always_ff @(posedge core_clk) begin
    if (srst || host_alert_n) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= low_q + 16'h0001;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("Read data outside read slot");
  a_alert_width: assert property ($rose(host_alert_n) |-> low_q == 16'(ALERT_CYC))
    else $error("Alert pulse length wrong");
  a_alert_cap: assert property (!host_alert_n |-> low_q < 16'(ALERT_CYC))
    else $error("Alert pulse too long");
  a_bat_stop: assert property (bat_ovp |=> chg_stop)
    else $error("Charging not stopped on battery overvoltage");
  a_buck_tshut: assert property (tshut && !boost_mode |=> conv_stop)
    else $error("Converter not stopped on shutdown");
  a_boost_ovp: assert property (boost_ovp && boost_mode |=> !boost_enable)
    else $error("Boost left enabled on overvoltage");
  a_boost_tshut: assert property (tshut && boost_mode |=> !boost_enable && bat_sw_off)
    else $error("Boost shutdown incomplete");
  a_therm_reg: assert property (therm_reg |=> timer_half_rate && term_disable)
    else $error("Thermal regulation effects missing");
  c_alert: cover property ($rose(host_alert_n));
  c_pump_low: cover property (input_current_limit == 5'h00);
  c_boost_off: cover property ($fell(boost_enable));
endmodule // csfi_checker

bind csfi_top csfi_checker #(.ALERT_CYC(ALERT_CYC)) u_csfi_checker (
  .core_clk(core_clk), .srst(srst), .rd_en(rd_en), .rdata(rdata),
  .host_alert_n(host_alert_n), .bat_ovp(bat_ovp), .chg_stop(chg_stop), .tshut(tshut),
  .boost_mode(boost_mode), .boost_ovp(boost_ovp), .conv_stop(conv_stop),
  .boost_enable(boost_enable), .bat_sw_off(bat_sw_off), .therm_reg(therm_reg),
  .timer_half_rate(timer_half_rate), .term_disable(term_disable),
  .input_current_limit(input_current_limit)
);

// ### tb/csfi_host_model.sv
// Host side model: counts alert pulses and measures their low time
`timescale 1ns/1ps
module csfi_host_model (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        host_alert_n,
  output logic      [7:0]  alert_cnt,
  output logic      [15:0] alert_len
);
  logic [15:0] run_q;
  // ==========================================================
  // Pulse counting
  always_ff @(posedge core_clk) begin
    if (srst) begin
      alert_cnt <= 8'h00;
      alert_len <= 16'h0000;
      run_q     <= 16'h0000;
    end else if (!host_alert_n) begin
      run_q <= run_q + 16'h0001;
      if (run_q == 16'h0000) begin
        alert_cnt <= alert_cnt + 8'h01;
      end
    end else begin
      if (run_q != 16'h0000) begin
        alert_len <= run_q;
      end
      run_q <= 16'h0000;
    end
  end
endmodule // csfi_host_model

// ### tb/charger_status_fault_interrupt_tb_top.sv
// Self-checking bench for the status, alert, fault and pump block
`timescale 1ns/1ps
module charger_status_fault_interrupt_tb_top;
  localparam int unsigned AC = 16;
  localparam int unsigned BH = 8;
  localparam int unsigned PP = 8;
  logic        core_clk, srst, wr_en, rd_en, chg_active, chg_done, timer_fault, sys_ovp;
  logic        boost_mode, boost_short, boost_ovp, therm_reg, tshut, bat_ovp, src_detected;
  logic        power_good_raw, input_good_raw, dpm_active, pv;
  logic        ind_o, ind_oe, host_alert_n, boost_enable, conv_stop, bat_sw_off, chg_stop;
  logic        timer_half_rate, term_disable;
  logic [7:0]  addr, wdata, rdata, alert_cnt, rv;
  logic [2:0]  thermistor_fault, input_type_raw;
  logic [3:0]  ovp_cmp;
  logic [4:0]  input_current_limit;
  logic [15:0] alert_len;
  logic [31:0] seed;
  int          fail_count, num_checks, n;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  csfi_top #(.ALERT_CYC(AC), .BLINK_HALF_CYC(BH), .PUMP_PHASE_CYC(PP)) uut (
    .core_clk(core_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .chg_active(chg_active), .chg_done(chg_done),
    .timer_fault(timer_fault), .sys_ovp(sys_ovp), .thermistor_fault(thermistor_fault),
    .ovp_cmp(ovp_cmp), .boost_mode(boost_mode), .boost_short(boost_short),
    .boost_ovp(boost_ovp), .therm_reg(therm_reg), .tshut(tshut), .bat_ovp(bat_ovp),
    .src_detected(src_detected), .input_type_raw(input_type_raw),
    .power_good_raw(power_good_raw), .input_good_raw(input_good_raw),
    .dpm_active(dpm_active), .ind_o(ind_o), .ind_oe(ind_oe), .host_alert_n(host_alert_n),
    .input_current_limit(input_current_limit), .boost_enable(boost_enable),
    .conv_stop(conv_stop), .bat_sw_off(bat_sw_off), .chg_stop(chg_stop),
    .timer_half_rate(timer_half_rate), .term_disable(term_disable)
  );

  csfi_host_model u_host (
    .core_clk(core_clk), .srst(srst), .host_alert_n(host_alert_n),
    .alert_cnt(alert_cnt), .alert_len(alert_len)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic note(input int t);
    $display("Scenario %0d finished", t);
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    tick(30000);
    fail_count++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    srst = 1'b1;
    seed = 32'ha80e4009;
    {wr_en, rd_en, chg_active, chg_done, timer_fault, sys_ovp, boost_mode, boost_short} = '0;
    {boost_ovp, therm_reg, tshut, bat_ovp, src_detected, power_good_raw} = '0;
    {input_good_raw, dpm_active, addr, wdata, thermistor_fault, input_type_raw, ovp_cmp} = '0;
    tick(20);
    srst <= 1'b0;
    rchk(csfi_pkg::A_CTRL0, 8'h17);
    rchk(csfi_pkg::A_CTRL1, 8'h60);
    rchk(8'h05, 8'h00);
    rchk(8'h20, 8'hff);
    note(1);
    bat_ovp <= 1'b1;
    tick(AC + 4);
    chk(alert_cnt, 16'h0001);
    chk(alert_len, 16'(AC));
    bat_ovp <= 1'b0;
    src_detected <= 1'b1;
    tick(AC + 4);
    chk(alert_cnt, 16'h0001);
    rchk(csfi_pkg::A_FAULT, 8'h08);
    rchk(csfi_pkg::A_FAULT, 8'h00);
    rchk(csfi_pkg::A_FLAG, 8'h02);
    chg_done <= 1'b1;
    tick(AC + 4);
    chk(alert_cnt, 16'h0002);
    rchk(csfi_pkg::A_FLAG, 8'h04);
    note(2);
    for (int s = 0; s < 4; s++) begin
      wr(csfi_pkg::A_CTRL1, 8'(s << 5));
      ovp_cmp <= 4'((1 << s) - 1);
      tick(2);
      rd(csfi_pkg::A_FAULT, rv);
      rchk(csfi_pkg::A_FAULT, 8'h00);
      ovp_cmp <= 4'((2 << s) - 1);
      tick(2);
      chk(conv_stop, 16'h0001);
      rchk(csfi_pkg::A_FAULT, 8'h10);
    end
    ovp_cmp <= 4'h0;
    tick(2);
    rchk(csfi_pkg::A_FAULT, 8'h10);
    rchk(csfi_pkg::A_FAULT, 8'h00);
    repeat (6) begin
      seed = xs(seed);
      thermistor_fault <= seed[2:0];
      tick(2);
      rchk(csfi_pkg::A_FAULT, {5'h00, seed[2:0]});
    end
    thermistor_fault <= 3'h0;
    note(3);
    chg_active <= 1'b1;
    tick(3);
    chk(ind_oe, 16'h0001);
    chk(ind_o, 16'h0000);
    chg_active <= 1'b0;
    tick(3);
    chk(ind_oe, 16'h0000);
    timer_fault <= 1'b1;
    tick(2);
    #1 n = 0;
    pv = ind_oe;
    repeat (4 * BH) begin
      tick(1);
      #1 n += int'(ind_oe !== pv);
      pv = ind_oe;
    end
    chk(16'(n), 16'h0004);
    timer_fault <= 1'b0;
    wr(csfi_pkg::A_CTRL1, 8'h61);
    wr(csfi_pkg::A_CTRL0, 8'h37);
    tick(3);
    chk(ind_oe, 16'h0001);
    wr(csfi_pkg::A_CTRL0, 8'h77);
    chg_active <= 1'b1;
    tick(3);
    chk(ind_oe, 16'h0000);
    chg_active <= 1'b0;
    note(4);
    wr(csfi_pkg::A_CTRL0, 8'h0a);
    wr(csfi_pkg::A_PUMP, 8'h02);
    tick(2);
    rchk(csfi_pkg::A_PUMP, 8'h00);
    chk(input_current_limit, 16'h000a);
    wr(csfi_pkg::A_PUMP, 8'h80);
    wr(csfi_pkg::A_PUMP, 8'h83);
    tick(2);
    rchk(csfi_pkg::A_PUMP, 8'h80);
    seed = xs(seed);
    rv = seed[0] ? 8'h82 : 8'h81;
    wr(csfi_pkg::A_PUMP, rv);
    #1 chk(input_current_limit, 16'h0000);
    rchk(csfi_pkg::A_PUMP, rv);
    n = 1;
    pv = 1'b1;
    repeat (8 * PP) begin
      tick(1);
      #1 n += int'(input_current_limit === 5'h00 && !pv);
      pv = (input_current_limit === 5'h00);
    end
    chk(16'(n), 16'(csfi_pkg::PUMP_PULSES));
    chk(input_current_limit, 16'h000a);
    rchk(csfi_pkg::A_PUMP, 8'h80);
    wr(csfi_pkg::A_PUMP, 8'h81);
    tick(3);
    wr(csfi_pkg::A_PUMP, 8'h00);
    tick(1);
    chk(input_current_limit, 16'h000a);
    rchk(csfi_pkg::A_PUMP, 8'h00);
    note(5);
    wr(csfi_pkg::A_CTRL1, 8'he0);
    boost_mode <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      boost_short <= 1'b1;
      tick(2);
      boost_short <= 1'b0;
      tick(2);
      if (i == 6) chk(boost_enable, 16'h0001);
    end
    chk(boost_enable, 16'h0000);
    rchk(csfi_pkg::A_FAULT, 8'h40);
    wr(csfi_pkg::A_CTRL1, 8'he0);
    rchk(csfi_pkg::A_FAULT, 8'h00);
    boost_ovp <= 1'b1;
    tick(2);
    boost_ovp <= 1'b0;
    chk(boost_enable, 16'h0000);
    rchk(csfi_pkg::A_FAULT, 8'h40);
    wr(csfi_pkg::A_CTRL1, 8'he0);
    tshut <= 1'b1;
    tick(2);
    chk(bat_sw_off, 16'h0001);
    tshut <= 1'b0;
    tick(2);
    chk(boost_enable, 16'h0000);
    boost_mode <= 1'b0;
    wr(csfi_pkg::A_CTRL1, 8'he0);
    note(6);
    {input_type_raw, power_good_raw, input_good_raw} <= 5'h17;
    therm_reg <= 1'b1;
    tick(2);
    rchk(csfi_pkg::A_STATUS, 8'hbd);
    rd(csfi_pkg::A_FAULT, rv);
    tshut <= 1'b1;
    tick(2);
    chk(conv_stop, 16'h0001);
    rchk(csfi_pkg::A_STATUS, 8'h05);
    rchk(csfi_pkg::A_FAULT, 8'h20);
    tshut <= 1'b0;
    therm_reg <= 1'b0;
    dpm_active <= 1'b1;
    tick(2);
    rchk(csfi_pkg::A_FLAG, 8'h09);
    rchk(csfi_pkg::A_FLAG, 8'h00);
    note(7);
    final_report();
  end
endmodule // charger_status_fault_interrupt_tb_top
